// *** rtl/ssf_top.sv ***
// Purpose: Tagged sample buffer with modes, level, flags and pin routing
// Assumes: Register port and sample inputs are on the core clock
// Notes: Switch depth only while in bypass; pointers are not remapped
// Overview of operation
// - Holds 128 words of one tag byte plus six data bytes.
// - Double depth gives 256 slots, 8-bit samples, two rate periods per word.
// - High-resolution batching stores 12-bit accel and temperature every sample period.
// - Double-depth words hold two 8-bit samples, written at half rate.
// - Accel-only batching drops temperature and stores 16-bit accel.
// - Three-bit mode field selects one of six buffer behaviours.
// - Watermark flag set while unread count is at or above threshold.
// - Overrun flag set when an unread word is overwritten.
// - Level field reports unread words; 128 means full at single depth.
// - Buffer flags route to pin one and pin two by two registers.
// - Mode 000 clears the buffer and stores nothing.
// - Mode 001 stores until full, then stops until restarted.
// - Rate changes insert a record with setting and timestamp.
// - Each word starts with a tag naming its source.
// - With aux routing set, pin one signals go to the aux pin.
// - Any routing bit makes the pin push-pull and drops its pull-down.
// - Pull-down off bits disconnect the pin pull-downs.
// - Mode 110 keeps storing; when full the oldest word is overwritten.
// - Mode 011 runs continuous until trigger edge, then stop-when-full.
// - Mode 100 stores nothing until trigger edge, then continuous from it.
// - Reading an empty buffer returns tag zero.
`timescale 1ns/100ps
`include "ssf_consts.svh"
`default_nettype none
module ssf_top import ssf_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   input wire logic i_smp_valid,
   input wire logic [15:0] i_acc_x,
   input wire logic [15:0] i_acc_y,
   input wire logic [15:0] i_acc_z,
   input wire logic [15:0] i_temp,
   input wire logic i_trig,
   input wire logic i_rate_chg,
   input wire logic [7:0] i_rate_cfg,
   input wire logic [31:0] i_tstamp,
   output logic o_irq1_o,
   output logic o_irq1_oe,
   output logic o_irq1_pd_en,
   output logic o_irq2_o,
   output logic o_irq2_oe,
   output logic o_irq2_pd_en,
   output logic o_aux_o,
   output logic o_aux_oe
);
   ssf_top_st_t q, s;
   logic [2:0] mode;
   logic ddep, full, trig_rise, pop, mwr, cont, fifo, byp, acc, ovw, wtm_now;
   logic r1any, r2any, lvl1, lvl2, aux, pk_wr;
   logic [8:0] cap;
   logic [7:0] pk_tag;
   logic [47:0] pk_data;
   logic [55:0] head;
   logic [7:0] didx;

   // Pointer step; wraps at the active depth
   function automatic logic [7:0] ssf_inc(input logic [7:0] p, input logic dd);
      return dd ? 8'(p + 8'h01) : {1'b0, 7'(p[6:0] + 7'h01)};
   endfunction : ssf_inc

   // ----------------------------------------
   // Word source and store
   // ----------------------------------------
   ssf_word_pack u_pack (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_smp_valid(i_smp_valid),
      .i_acc_x(i_acc_x),
      .i_acc_y(i_acc_y),
      .i_acc_z(i_acc_z),
      .i_temp(i_temp),
      .i_ddep(ddep),
      .i_xlo(q.wtm[`SSF_B_XLO]),
      .i_cfg_en(q.mctl[`SSF_B_CFGEN]),
      .i_rate_chg(i_rate_chg),
      .i_rate_cfg(i_rate_cfg),
      .i_tstamp(i_tstamp),
      .o_wr(pk_wr),
      .o_tag(pk_tag),
      .o_data(pk_data)
   );

   ssf_word_mem u_mem (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_we(acc),
      .i_waddr(q.wp),
      .i_wdata({pk_tag, pk_data}),
      .i_raddr(s.rp),
      .o_rdata(head)
   );

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   // Trigger is same-clock logic, so only an edge detector is needed
   assign mode = q.mctl[2:0];
   assign ddep = q.mctl[`SSF_B_DDEP];
   assign cap = ddep ? `SSF_CAP2 : `SSF_CAP1;
   assign full = (q.cnt == cap);
   assign trig_rise = i_trig & ~q.trig_d;
   assign mwr = i_reg_wr && i_reg_addr == `SSF_A_MODE;
   assign pop = i_reg_rd && i_reg_addr == `SSF_A_DLAST && q.cnt != 9'h000;
   assign cont = mode == `SSF_M_CONT || (mode == `SSF_M_C2F && q.phase == PH_RUN)
      || (mode == `SSF_M_B2C && (q.phase == PH_TRIG || (q.phase == PH_RUN && trig_rise)));
   assign fifo = mode == `SSF_M_FIFO || (mode == `SSF_M_B2F && i_trig)
      || (mode == `SSF_M_C2F && q.phase != PH_RUN);
   assign byp = ~cont & ~fifo;
   // A full stop-when-full buffer takes no word until the mode is rewritten
   assign acc = pk_wr & (cont | (fifo & ~full & q.phase != PH_HALT));
   assign ovw = acc & full & ~pop & cont;
   assign wtm_now = q.cnt >= {2'b00, q.wtm[6:0]};
   assign didx = 8'(i_reg_addr - `SSF_A_D0);

   // Pin levels from the flags each pin has routed to it
   assign aux = q.ctl1[`SSF_B_AUX];
   assign r1any = |q.rt1[`SSF_B_RFULL:`SSF_B_RWTM];
   assign r2any = |q.rt2[`SSF_B_RFULL:`SSF_B_RWTM];
   assign lvl1 = (wtm_now & q.rt1[`SSF_B_RWTM]) | (q.ovr & q.rt1[`SSF_B_ROVR])
      | (full & q.rt1[`SSF_B_RFULL]);
   assign lvl2 = (wtm_now & q.rt2[`SSF_B_RWTM]) | (q.ovr & q.rt2[`SSF_B_ROVR])
      | (full & q.rt2[`SSF_B_RFULL]);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s = q;
      s.trig_d = i_trig;
      s.rvalid = i_reg_rd;
      // Register writes
      if (i_reg_wr) begin
         case (i_reg_addr)
            `SSF_A_PIN: s.pin = i_reg_wdata;
            `SSF_A_CTL1: s.ctl1 = i_reg_wdata;
            `SSF_A_RT1: s.rt1 = i_reg_wdata;
            `SSF_A_RT2: s.rt2 = i_reg_wdata;
            `SSF_A_MODE: s.mctl = i_reg_wdata;
            `SSF_A_WTM: s.wtm = i_reg_wdata;
            default: s.wtm = q.wtm;
         endcase
      end
      // Trigger phase; any mode write restarts collection
      if (mwr) begin
         s.phase = PH_RUN;
      end else if (fifo && full && !pop) begin
         s.phase = PH_HALT;
      end else if (trig_rise && q.phase == PH_RUN && (mode == `SSF_M_C2F || mode == `SSF_M_B2C)) begin
         s.phase = PH_TRIG;
      end
      // Pointers and count
      if (byp) begin
         s.cnt = 9'h000;
         s.wp = 8'h00;
         s.rp = 8'h00;
         s.ovr = 1'b0;
      end else begin
         if (acc) begin
            s.wp = ssf_inc(q.wp, ddep);
         end
         if (pop || ovw) begin
            s.rp = ssf_inc(q.rp, ddep);
         end
         if (acc && !pop && !ovw) begin
            s.cnt = 9'(q.cnt + 9'h001);
         end else if (pop && !acc) begin
            s.cnt = 9'(q.cnt - 9'h001);
         end
         // A read clears the flag; no overwrite is counted in a cycle with a read
         s.ovr = ovw | (q.ovr & ~pop);
      end
      // Register reads; data bytes come from the oldest word
      s.rdata = 8'h00;
      if (i_reg_rd) begin
         case (i_reg_addr)
            `SSF_A_PIN: s.rdata = q.pin;
            `SSF_A_CTL1: s.rdata = q.ctl1;
            `SSF_A_RT1: s.rdata = q.rt1;
            `SSF_A_RT2: s.rdata = q.rt2;
            `SSF_A_MODE: s.rdata = q.mctl;
            `SSF_A_WTM: s.rdata = q.wtm;
            `SSF_A_FLG: s.rdata = {wtm_now, q.ovr, q.cnt[8], 5'h00};
            `SSF_A_LVL: s.rdata = q.cnt[7:0];
            `SSF_A_TAG: s.rdata = (q.cnt != 9'h000) ? head[55:48] : 8'h00;
            default: begin
               if (i_reg_addr >= `SSF_A_D0 && i_reg_addr <= `SSF_A_DLAST) begin
                  s.rdata = 8'(head[47:0] >> {didx[2:0], 3'b000});
               end
            end
         endcase
      end
      // Pins: routed pins drive push-pull, idle pins keep the pull-down
      s.i1oe = r1any & ~aux;
      s.i1o = lvl1 & ~aux;
      s.i1pd = ~s.i1oe & ~q.pin[`SSF_B_PD1];
      s.auxoe = r1any & aux;
      s.auxo = lvl1 & aux;
      s.i2oe = r2any;
      s.i2o = lvl2;
      s.i2pd = ~r2any & ~q.pin[`SSF_B_PD2];
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= s;
      end
   end

   // Outputs straight from the state register
   assign o_reg_rdata = q.rdata;
   assign o_reg_rvalid = q.rvalid;
   assign o_irq1_o = q.i1o;
   assign o_irq1_oe = q.i1oe;
   assign o_irq1_pd_en = q.i1pd;
   assign o_irq2_o = q.i2o;
   assign o_irq2_oe = q.i2oe;
   assign o_irq2_pd_en = q.i2pd;
   assign o_aux_o = q.auxo;
   assign o_aux_oe = q.auxoe;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_empty_tag_rd;
      i_reg_rd && i_reg_addr == `SSF_A_TAG && q.cnt == 9'h000;
   endsequence
   sequence s_trig_store;
      mode == `SSF_M_B2C && q.phase == PH_RUN && trig_rise && pk_wr && !mwr;
   endsequence
   sequence s_clr;
      mwr && i_reg_wdata[2:0] == `SSF_M_BYP;
   endsequence
   sequence s_rearm;
      !mwr ##1 mwr && i_reg_wdata[2:0] == `SSF_M_FIFO;
   endsequence

   bypass_empty_a: assert property (mode == `SSF_M_BYP && !mwr |=> q.cnt == 9'h000 ##1 q.cnt == 9'h000)
      else $error("count not zero in bypass");
   count_bound_a: assert property (q.cnt <= cap)
      else $error("count above capacity");
   full_stop_a: assert property (mode == `SSF_M_FIFO && full && !pop && !mwr |=> full && q.phase == PH_HALT)
      else $error("stop-when-full buffer changed level");
   overrun_set_a: assert property (ovw |=> q.ovr && q.cnt == $past(q.cnt))
      else $error("overwrite did not raise overrun");
   count_step_a: assert property (acc && !pop && !byp && !full |=> q.cnt == 9'($past(q.cnt) + 9'h001))
      else $error("write did not raise count");
   empty_tag_a: assert property (s_empty_tag_rd |=> o_reg_rdata == 8'h00 && o_reg_rvalid)
      else $error("empty read gave a tag");
   wtm_read_a: assert property (i_reg_rd && i_reg_addr == `SSF_A_FLG |=> o_reg_rdata[7] == ($past(q.cnt) >=
      {2'b00, $past(q.wtm[6:0])})) else $error("watermark bit wrong");
   pin_drive_a: assert property (r1any && !aux |=> o_irq1_oe && !o_irq1_pd_en)
      else $error("routed pin not driven");
   aux_route_a: assert property (r1any && aux |=> o_aux_oe && !o_irq1_oe)
      else $error("aux routing not applied");
   trig_store_a: assert property (s_trig_store |=> q.cnt != 9'h000 && q.phase == PH_TRIG)
      else $error("trigger sample not stored");

   // ----------------------------------------
   // Level, phase and pin checks
   // ----------------------------------------
   // Level moves one step per word read out
   pop_step_a: assert property (pop && !acc && !byp |=> q.cnt == 9'($past(q.cnt) - 9'h001))
      else $error("read did not lower count");
   // A halted buffer ignores new words until the mode is rewritten
   halt_hold_a: assert property (q.phase == PH_HALT && !mwr && !pop && !byp |=> q.cnt == $past(q.cnt))
      else $error("halted buffer took a word");
   // Clearing leaves no stale overrun or write position behind
   bypass_flag_a: assert property (byp |=> !q.ovr && q.wp == 8'h00)
      else $error("bypass kept overrun");
   // The read side advances exactly one slot, wrapping at the active depth
   rp_step_a: assert property ((pop || ovw) && !byp |=> q.rp == ssf_inc($past(q.rp), $past(ddep)))
      else $error("read pointer skipped");
   pin_two_a: assert property (r2any |=> o_irq2_oe && !o_irq2_pd_en)
      else $error("pin two not driven");
   pd_off_a: assert property (!r1any && q.pin[`SSF_B_PD1] |=> !o_irq1_pd_en)
      else $error("pull-down not disconnected");
   aux_off_a: assert property (!aux |=> !o_aux_oe && !o_aux_o)
      else $error("aux pin driven without routing");
   // Clear then re-arm of stop-when-full must give an empty, running buffer
   restart_empty_a: assert property (s_clr ##1 s_rearm |=> q.cnt == 9'h000 && q.phase == PH_RUN)
      else $error("restart left words behind");
endmodule : ssf_top
`default_nettype wire

// *** rtl/ssf_consts.svh ***
// Purpose: Offsets, field positions, codes and sizes of the sample buffer
// Assumes: Included by bare name from design files
// Notes: Definitions only
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSF_A_PIN 8'h0c
`define SSF_A_CTL1 8'h10
`define SSF_A_RT1 8'h11
`define SSF_A_RT2 8'h12
`define SSF_A_MODE 8'h15
`define SSF_A_WTM 8'h16
`define SSF_A_FLG 8'h26
`define SSF_A_LVL 8'h27
`define SSF_A_TAG 8'h40
`define SSF_A_D0 8'h41
`define SSF_A_DLAST 8'h46
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SSF_B_PD1 7
`define SSF_B_PD2 6
`define SSF_B_AUX 4
`define SSF_B_RWTM 3
`define SSF_B_ROVR 4
`define SSF_B_RFULL 5
`define SSF_B_DDEP 7
`define SSF_B_CFGEN 3
`define SSF_B_XLO 7
// ----------------------------------------
// Buffer modes, sizes and tags
// ----------------------------------------
`define SSF_M_BYP 3'h0
`define SSF_M_FIFO 3'h1
`define SSF_M_C2F 3'h3
`define SSF_M_B2C 3'h4
`define SSF_M_CONT 3'h6
`define SSF_M_B2F 3'h7
`define SSF_CAP1 9'h080
`define SSF_CAP2 9'h100
`define SSF_T_XL 5'h02
`define SSF_T_TMP 5'h03
`define SSF_T_X2 5'h04
`define SSF_T_CFG 5'h1e
`endif

// *** rtl/ssf_pkg.sv ***
// Purpose: Types shared by the sample buffer modules
// Assumes: Nothing beyond SystemVerilog
// Notes: Each module keeps all its state in one struct from here
package ssf_pkg;
   typedef enum logic [1:0] {PH_RUN, PH_TRIG, PH_HALT} ssf_phase_t;

   typedef struct packed {
      logic [255:0][55:0] arr;
      logic [55:0] rd;
   } ssf_mem_st_t;

   typedef struct packed {
      logic [23:0] prv;
      logic half;
      logic tp;
      logic [15:0] tv;
      logic mp;
      logic [47:0] md;
      logic wr;
      logic [7:0] tag;
      logic [47:0] data;
   } ssf_pack_st_t;

   typedef struct packed {
      logic [7:0] pin, ctl1, rt1, rt2, mctl, wtm;
      logic [8:0] cnt;
      logic [7:0] wp, rp;
      logic ovr;
      ssf_phase_t phase;
      logic trig_d;
      logic [7:0] rdata;
      logic rvalid;
      logic i1o, i1oe, i1pd, i2o, i2oe, i2pd, auxo, auxoe;
   } ssf_top_st_t;

   // Keep the upper 12 bits, left-justified
   function automatic logic [15:0] ssf_hi12(input logic [15:0] v);
      return {v[15:4], 4'h0};
   endfunction : ssf_hi12
endpackage : ssf_pkg

// *** rtl/ssf_word_mem.sv ***
// Purpose: 256 x 56-bit word store with registered read
// Assumes: One write and one read port on the core clock
// Notes: Write-first, so a word written to the read address shows at once
`timescale 1ns/100ps
`default_nettype none
module ssf_word_mem import ssf_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_we,
   input wire logic [7:0] i_waddr,
   input wire logic [55:0] i_wdata,
   input wire logic [7:0] i_raddr,
   output logic [55:0] o_rdata
);
   ssf_mem_st_t q, s;

   // Store and fetch; bypass avoids a stale head after writing an empty buffer
   always_comb begin
      s = q;
      if (i_we) begin
         s.arr[i_waddr] = i_wdata;
      end
      s.rd = (i_we && i_waddr == i_raddr) ? i_wdata : q.arr[i_raddr];
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= s;
      end
   end

   assign o_rdata = q.rd;
endmodule : ssf_word_mem
`default_nettype wire

// *** rtl/ssf_word_pack.sv ***
// Purpose: Forms tagged seven-byte words from samples and rate changes
// Assumes: Samples arrive far apart compared to the core clock
// Notes: At most one word per cycle; pending words drain in idle cycles
`timescale 1ns/100ps
`include "ssf_consts.svh"
`default_nettype none
module ssf_word_pack import ssf_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_smp_valid,
   input wire logic [15:0] i_acc_x,
   input wire logic [15:0] i_acc_y,
   input wire logic [15:0] i_acc_z,
   input wire logic [15:0] i_temp,
   input wire logic i_ddep,
   input wire logic i_xlo,
   input wire logic i_cfg_en,
   input wire logic i_rate_chg,
   input wire logic [7:0] i_rate_cfg,
   input wire logic [31:0] i_tstamp,
   output logic o_wr,
   output logic [7:0] o_tag,
   output logic [47:0] o_data
);
   ssf_pack_st_t q, s;

   // ----------------------------------------
   // Word forming
   // ----------------------------------------
   // Samples take priority; a pending temperature or record waits a cycle
   always_comb begin
      s = q;
      s.wr = 1'b0;
      if (!i_ddep) begin
         s.half = 1'b0;
      end
      if (i_smp_valid) begin
         if (i_ddep) begin
            // Two output-rate samples, top 8 bits each, per word
            s.half = ~q.half;
            s.prv = {i_acc_z[15:8], i_acc_y[15:8], i_acc_x[15:8]};
            if (q.half) begin
               s.wr = 1'b1;
               s.tag = {`SSF_T_X2, 3'h0};
               s.data = {i_acc_z[15:8], i_acc_y[15:8], i_acc_x[15:8], q.prv};
            end
         end else begin
            s.wr = 1'b1;
            s.tag = {`SSF_T_XL, 3'h0};
            if (i_xlo) begin
               s.data = {i_acc_z, i_acc_y, i_acc_x};
            end else begin
               s.data = {ssf_hi12(i_acc_z), ssf_hi12(i_acc_y), ssf_hi12(i_acc_x)};
               s.tp = 1'b1;
               s.tv = ssf_hi12(i_temp);
            end
         end
      end else if (q.mp) begin
         s.wr = 1'b1;
         s.tag = {`SSF_T_CFG, 3'h0};
         s.data = q.md;
         s.mp = 1'b0;
      end else if (q.tp) begin
         s.wr = 1'b1;
         s.tag = {`SSF_T_TMP, 3'h0};
         s.data = {32'h0000_0000, q.tv};
         s.tp = 1'b0;
      end
      // A change record carries the new setting and its time
      if (i_rate_chg && i_cfg_en) begin
         s.mp = 1'b1;
         s.md = {i_tstamp, i_rate_cfg, 8'h00};
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= s;
      end
   end

   assign o_wr = q.wr;
   assign o_tag = q.tag;
   assign o_data = q.data;
endmodule : ssf_word_pack
`default_nettype wire

// *** testbench/ssf_host_model.sv ***
// Purpose: Host processor model on the buffer's register port
// Assumes: Strobes and address launched just after a rising edge
// Notes: Idle address and data show inverted values, so stale lines never look valid
`timescale 1ns/100ps
`default_nettype none
module ssf_host_model (
   input wire logic i_core_clk,
   input wire logic [7:0] i_reg_rdata,
   input wire logic i_reg_rvalid,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [7:0] o_reg_addr,
   output logic [7:0] o_reg_wdata
);
   // Quiet bus from time zero
   initial begin
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_addr = 8'hff;
      o_reg_wdata = 8'hff;
   end
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   // One-cycle write strobe, taken at the next edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      o_reg_wr <= 1'b1;
      o_reg_addr <= a;
      o_reg_wdata <= d;
      @(posedge i_core_clk);
      o_reg_wr <= 1'b0;
      o_reg_addr <= ~a;
      o_reg_wdata <= ~d;
   endtask : wr
   // Read; the answer is waited for under a bounded count
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge i_core_clk);
      o_reg_rd <= 1'b1;
      o_reg_addr <= a;
      @(posedge i_core_clk);
      o_reg_rd <= 1'b0;
      o_reg_addr <= ~a;
      for (int n = 0; n < 4; n++) begin
         @(posedge i_core_clk);
         if (i_reg_rvalid === 1'b1) begin
            d = i_reg_rdata;
            break;
         end
      end
   endtask : rd
   // Whole word: tag first, then six data bytes; the last byte pops
   task automatic rd_word(output logic [55:0] w);
      logic [7:0] b;
      for (int i = 0; i < 7; i++) begin
         rd(8'(64 + i), b);
         w[i*8 +: 8] = b;
      end
   endtask : rd_word
   // Emptying a halted buffer needs bypass before the mode is set again
   task automatic restart;
      wr(8'h15, 8'h00);
      wr(8'h15, 8'h01);
   endtask : restart
endmodule : ssf_host_model
`default_nettype wire

// *** testbench/ssf_top_bench.sv ***
// Purpose: Self-checking bench for the tagged sample buffer
// Assumes: Host model owns the register port; bench drives samples
// Notes: Accel-only batching keeps sample bytes easy to predict
`timescale 1ns/100ps
`default_nettype none
module ssf_top_bench;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr, reg_rd, reg_rvalid, smp_valid = 1'b0, trig = 1'b0, rate_chg = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v, rate_cfg = 8'h00;
   logic [15:0] ax = 16'h0000, ay = 16'h0000, az = 16'h0000, tmp = 16'h0000;
   logic [31:0] tstamp = 32'h0000_0000;
   wire logic [7:0] pins;
   logic [55:0] w;
   int fail_count = 0;
   int compares = 0;
   // ----------------------------------------
   // Clock, design and host
   // ----------------------------------------
   always #50 core_clk = ~core_clk;
   ssf_top DUT (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
      .i_smp_valid(smp_valid), .i_acc_x(ax), .i_acc_y(ay), .i_acc_z(az), .i_temp(tmp), .i_trig(trig),
      .i_rate_chg(rate_chg), .i_rate_cfg(rate_cfg), .i_tstamp(tstamp), .o_irq1_o(pins[7]),
      .o_irq1_oe(pins[6]), .o_irq1_pd_en(pins[5]), .o_irq2_o(pins[4]), .o_irq2_oe(pins[3]),
      .o_irq2_pd_en(pins[2]), .o_aux_o(pins[1]), .o_aux_oe(pins[0]));
   ssf_host_model host (.i_core_clk(core_clk), .i_reg_rdata(reg_rdata), .i_reg_rvalid(reg_rvalid),
      .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, v);
      chk($sformatf("reg %h", a), e, v);
   endtask : rchk
   // Pins are registered, so let them settle before looking
   task automatic pchk(input logic [7:0] e);
      repeat (3) @(posedge core_clk);
      chk("pins", e, pins);
   endtask : pchk
   // Samples three cycles apart leave room for a temperature word
   task automatic smp(input logic [15:0] x, input logic tg);
      @(posedge core_clk);
      smp_valid <= 1'b1;
      ax <= x;
      ay <= x;
      az <= x;
      tmp <= ~x;
      @(posedge core_clk);
      smp_valid <= 1'b0;
      // Trigger rises with the packed word, so the trigger sample is kept
      trig <= tg;
      @(posedge core_clk);
   endtask : smp
   task automatic many(input int lo, input int hi);
      for (int k = lo; k <= hi; k++) begin
         smp({8'h3c, 8'(k)}, 1'b0);
      end
   endtask : many
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      pchk(8'h24);
      rchk(8'h27, 8'h00);
      rchk(8'h26, 8'h80);
      rchk(8'h15, 8'h00);
      rchk(8'h3f, 8'h00);
      host.wr(8'h27, 8'h55);
      rchk(8'h27, 8'h00);
   endtask : t_reset
   task automatic t_fifo;
      host.wr(8'h16, 8'h85);
      host.wr(8'h15, 8'h01);
      many(0, 3);
      rchk(8'h26, 8'h00);
      many(4, 4);
      rchk(8'h26, 8'h80);
      many(5, 129);
      rchk(8'h27, 8'h80);
      rchk(8'h26, 8'h80);
      host.rd_word(w);
      chk("tag", 8'h10, w[7:0]);
      chk("byte0", 8'h00, w[15:8]);
      chk("byte1", 8'h3c, w[23:16]);
      rchk(8'h27, 8'h7f);
      many(200, 200);
      rchk(8'h27, 8'h7f);
      host.restart();
      rchk(8'h27, 8'h00);
      host.rd_word(w);
      chk("empty tag", 8'h00, w[7:0]);
   endtask : t_fifo
   task automatic t_cont;
      host.wr(8'h15, 8'h06);
      many(0, 128);
      rchk(8'h27, 8'h80);
      rchk(8'h26, 8'hc0);
      host.rd_word(w);
      chk("oldest", 8'h01, w[15:8]);
      rchk(8'h26, 8'h80);
      host.wr(8'h15, 8'h00);
      rchk(8'h27, 8'h00);
   endtask : t_cont
   task automatic t_res;
      host.wr(8'h16, 8'h05);
      host.wr(8'h15, 8'h06);
      smp(16'h1234, 1'b0);
      rchk(8'h27, 8'h02);
      host.rd_word(w);
      chk("acc tag", 8'h10, w[7:0]);
      chk("acc low", 8'h30, w[15:8]);
      host.rd_word(w);
      chk("temp tag", 8'h18, w[7:0]);
      chk("temp high", 8'hed, w[23:16]);
      host.wr(8'h15, 8'h00);
   endtask : t_res
   task automatic t_dbl;
      host.wr(8'h16, 8'h80);
      host.wr(8'h15, 8'h80);
      host.wr(8'h15, 8'h86);
      smp(16'h1100, 1'b0);
      smp(16'h2200, 1'b0);
      rchk(8'h27, 8'h01);
      host.rd_word(w);
      chk("x2 tag", 8'h20, w[7:0]);
      chk("prev", 8'h11, w[15:8]);
      chk("curr", 8'h22, w[39:32]);
      host.wr(8'h15, 8'h80);
      host.wr(8'h15, 8'h00);
   endtask : t_dbl
   task automatic t_trig;
      host.wr(8'h15, 8'h04);
      smp(16'h0101, 1'b0);
      rchk(8'h27, 8'h00);
      smp(16'h0202, 1'b1);
      rchk(8'h27, 8'h01);
      host.rd_word(w);
      chk("trig smp", 8'h02, w[15:8]);
      trig <= 1'b0;
      host.wr(8'h15, 8'h00);
      // Bypass-to-stop keeps words only while the trigger stands
      host.wr(8'h15, 8'h07);
      smp(16'h0404, 1'b1);
      rchk(8'h27, 8'h01);
      trig <= 1'b0;
      rchk(8'h27, 8'h00);
      // Continuous until the edge, then stop once full
      host.wr(8'h15, 8'h03);
      many(0, 128);
      smp(16'h3c99, 1'b1);
      trig <= 1'b0;
      host.rd_word(w);
      chk("c2f oldest", 8'h02, w[15:8]);
      smp(16'h3c55, 1'b0);
      rchk(8'h27, 8'h7f);
      host.wr(8'h15, 8'h00);
   endtask : t_trig
   task automatic t_rec;
      host.wr(8'h15, 8'h0e);
      @(posedge core_clk);
      rate_chg <= 1'b1;
      rate_cfg <= 8'ha5;
      tstamp <= 32'h9b22_3344;
      @(posedge core_clk);
      rate_chg <= 1'b0;
      // Record needs a packer cycle and a store cycle before it counts
      repeat (2) @(posedge core_clk);
      host.rd_word(w);
      chk("rec tag", 8'hf0, w[7:0]);
      chk("rec cfg", 8'ha5, w[23:16]);
      chk("rec time", 8'h9b, w[55:48]);
      host.wr(8'h15, 8'h00);
   endtask : t_rec
   task automatic t_pins;
      host.wr(8'h16, 8'h81);
      host.wr(8'h15, 8'h06);
      host.wr(8'h11, 8'h08);
      host.wr(8'h12, 8'h10);
      smp(16'h0303, 1'b0);
      pchk(8'hc8);
      host.wr(8'h10, 8'h10);
      pchk(8'h2b);
      host.wr(8'h10, 8'h00);
      host.wr(8'h11, 8'h00);
      host.wr(8'h12, 8'h00);
      host.wr(8'h0c, 8'hc0);
      host.wr(8'h15, 8'h00);
      pchk(8'h00);
   endtask : t_pins
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_fifo();
      t_cont();
      t_res();
      t_dbl();
      t_trig();
      t_rec();
      t_pins();
      report_and_stop();
   end
   // About twenty-five times the expected run length
   initial begin
      #4_000_000;
      fail_count++;
      report_and_stop();
   end
endmodule : ssf_top_bench
`default_nettype wire
